/* File: hdl/sxa_pkg.sv */
// Constants and types for the subtract, exclusive-OR and swap datapath slice
// Function
// - Subtract working register from file register
// - Subtract updates carry, digit-carry, zero flags
// - Destination bit 0 to working, 1 to file
// - Literal XOR into working, zero flag only
// - Nibble swap of file register, flags unchanged
// - File XOR routed by destination, zero only
package sxa_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [ADDR_W-1:0] FILE_ADDR_MAX = 7'h7f;
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam int EXEC_CYCLES = 2;

  typedef enum logic [2:0]
  {
    sxa_op_none,
    sxa_op_subtract_from_file_op,
    sxa_op_xor_literal_op,
    sxa_op_nibble_swap_op,
    sxa_op_xor_with_file_op
  } sxa_op_e;
endpackage

/* File: hdl/sxa_file_mem.sv */
// File register memory with registered read data
`timescale 1ns/1ps
module sxa_file_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int DEPTH = 128
) (
  input wire logic clock,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // sxa_file_mem

/* File: hdl/sxa_alu.sv */
// Datapath slice executing subtract, XOR and nibble swap instructions
`timescale 1ns/1ps
module sxa_alu (
  input wire logic clock,
  input wire logic rstn,
  input wire logic op_valid,
  input wire sxa_pkg::sxa_op_e op,
  input wire logic [sxa_pkg::ADDR_W-1:0] file_addr,
  input wire logic dest_sel,
  input wire logic [sxa_pkg::DATA_W-1:0] literal,
  input wire logic load_en,
  input wire logic [sxa_pkg::ADDR_W-1:0] load_addr,
  input wire logic [sxa_pkg::DATA_W-1:0] load_data,
  output logic busy,
  output logic done,
  output logic [sxa_pkg::DATA_W-1:0] result,
  output logic [sxa_pkg::DATA_W-1:0] working,
  output logic file_wr,
  output logic [sxa_pkg::ADDR_W-1:0] file_wr_addr,
  output logic [sxa_pkg::DATA_W-1:0] file_wr_data,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag
);
  import sxa_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic
  {
    sxa_st_idle,
    sxa_st_exec
  } sxa_state_e;

  sxa_state_e state;
  sxa_state_e next_state;
  sxa_op_e cur_op;
  sxa_op_e next_cur_op;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_cur_addr;
  logic cur_dest;
  logic next_cur_dest;
  logic [DATA_W-1:0] cur_lit;
  logic [DATA_W-1:0] next_cur_lit;
  logic [DATA_W-1:0] next_working;
  logic [DATA_W-1:0] next_result;
  logic next_done;
  logic next_busy;
  logic next_file_wr;
  logic [ADDR_W-1:0] next_file_wr_addr;
  logic [DATA_W-1:0] next_file_wr_data;
  logic next_carry_flag;
  logic next_digit_carry_flag;
  logic next_zero_flag;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] alu_out;
  logic [ADDR_W-1:0] mem_wr_addr;
  logic [DATA_W-1:0] mem_wr_data;
  logic mem_wr_en;

  // ------------------------------------------------------------
  // File registers
  // ------------------------------------------------------------
  always_comb
  begin
    mem_wr_en = load_en | next_file_wr;
    mem_wr_addr = next_file_wr ? next_file_wr_addr : load_addr;
    mem_wr_data = next_file_wr ? next_file_wr_data : load_data;
  end

  sxa_file_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W),
    .DEPTH(FILE_DEPTH)
  ) u_mem (
    .clock(clock),
    .rd_addr(file_addr),
    .rd_data(file_val),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_cur_op = cur_op;
    next_cur_addr = cur_addr;
    next_cur_dest = cur_dest;
    next_cur_lit = cur_lit;
    next_working = working;
    next_result = result;
    next_done = 1'b0;
    next_busy = 1'b0;
    next_file_wr = 1'b0;
    next_file_wr_addr = file_wr_addr;
    next_file_wr_data = file_wr_data;
    next_carry_flag = carry_flag;
    next_digit_carry_flag = digit_carry_flag;
    next_zero_flag = zero_flag;
    alu_out = file_val;
    unique case (state)
      sxa_st_idle:
      begin
        if (op_valid && op != sxa_op_none)
        begin
          next_state = sxa_st_exec;
          next_cur_op = op;
          next_cur_addr = file_addr;
          next_cur_dest = dest_sel;
          next_cur_lit = literal;
          next_busy = 1'b1;
        end
      end
      sxa_st_exec:
      begin
        next_state = sxa_st_idle;
        next_done = 1'b1;
        unique case (cur_op)
          sxa_op_subtract_from_file_op:
          begin
            alu_out = file_val - working;
            next_carry_flag = (working <= file_val);
            next_digit_carry_flag = (working[NIB_HI-1:NIB_LO] <= file_val[NIB_HI-1:NIB_LO]);
            next_zero_flag = (alu_out == '0);
          end
          sxa_op_xor_literal_op:
          begin
            alu_out = working ^ cur_lit;
            next_zero_flag = (alu_out == '0);
          end
          sxa_op_nibble_swap_op:
          begin
            alu_out = {file_val[NIB_HI-1:NIB_LO], file_val[DATA_W-1:NIB_HI]};
          end
          sxa_op_xor_with_file_op:
          begin
            alu_out = working ^ file_val;
            next_zero_flag = (alu_out == '0);
          end
          default:
          begin
            alu_out = file_val;
          end
        endcase
        next_result = alu_out;
        // Literal form always targets working register
        if (cur_op == sxa_op_xor_literal_op || cur_dest == DEST_WORKING)
        begin
          next_working = alu_out;
        end
        else
        begin
          next_file_wr = 1'b1;
          next_file_wr_addr = cur_addr;
          next_file_wr_data = alu_out;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= sxa_st_idle;
      cur_op <= sxa_op_none;
      cur_addr <= '0;
      cur_dest <= DEST_WORKING;
      cur_lit <= '0;
      working <= W_RESET;
      result <= '0;
      done <= 1'b0;
      busy <= 1'b0;
      file_wr <= 1'b0;
      file_wr_addr <= '0;
      file_wr_data <= '0;
      carry_flag <= FLAG_RESET;
      digit_carry_flag <= FLAG_RESET;
      zero_flag <= FLAG_RESET;
    end
    else
    begin
      state <= next_state;
      cur_op <= next_cur_op;
      cur_addr <= next_cur_addr;
      cur_dest <= next_cur_dest;
      cur_lit <= next_cur_lit;
      working <= next_working;
      result <= next_result;
      done <= next_done;
      busy <= next_busy;
      file_wr <= next_file_wr;
      file_wr_addr <= next_file_wr_addr;
      file_wr_data <= next_file_wr_data;
      carry_flag <= next_carry_flag;
      digit_carry_flag <= next_digit_carry_flag;
      zero_flag <= next_zero_flag;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sub_result_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_op == sxa_op_subtract_from_file_op)
      |=> result == 8'($past(file_val) - $past(working)))
    else $error("subtract result wrong");
  sub_carry_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_op == sxa_op_subtract_from_file_op)
      |=> carry_flag == ($past(working) <= $past(file_val)))
    else $error("carry wrong after subtract");
  sub_dcarry_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_op == sxa_op_subtract_from_file_op)
      |=> digit_carry_flag == ($past(working[3:0]) <= $past(file_val[3:0])))
    else $error("digit carry wrong after subtract");
  dest_file_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_op != sxa_op_xor_literal_op && cur_dest == DEST_FILE)
      |=> file_wr && $stable(working) && file_wr_data == result)
    else $error("file destination not honoured");
  dest_work_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_dest == DEST_WORKING) |=> !file_wr && working == result)
    else $error("working destination not honoured");
  lit_xor_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_op == sxa_op_xor_literal_op)
      |=> working == ($past(working) ^ $past(cur_lit)) && $stable(carry_flag)
        && $stable(digit_carry_flag) && !file_wr)
    else $error("literal xor wrong");
  swap_flags_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_op == sxa_op_nibble_swap_op)
      |=> result == {$past(file_val[3:0]), $past(file_val[7:4])} && $stable(zero_flag)
        && $stable(carry_flag) && $stable(digit_carry_flag))
    else $error("nibble swap wrong");
  file_xor_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == sxa_st_exec && cur_op == sxa_op_xor_with_file_op)
      |=> result == ($past(working) ^ $past(file_val)) && $stable(carry_flag))
    else $error("file xor wrong");
  zero_flag_a: assert property (@(posedge clock) disable iff (!rstn)
    (done && $past(cur_op) != sxa_op_nibble_swap_op) |-> zero_flag == (result == 8'h00))
    else $error("zero flag disagrees with result");
endmodule // sxa_alu

/* File: testbench/sxa_dec_model.sv */
// Decoder and register file loader model driving the datapath inputs
`timescale 1ns/1ps
module sxa_dec_model (
  input wire logic clock,
  output logic op_valid,
  output sxa_pkg::sxa_op_e op,
  output logic [sxa_pkg::ADDR_W-1:0] file_addr,
  output logic dest_sel,
  output logic [sxa_pkg::DATA_W-1:0] literal,
  output logic load_en,
  output logic [sxa_pkg::ADDR_W-1:0] load_addr,
  output logic [sxa_pkg::DATA_W-1:0] load_data
);
  import sxa_pkg::*;
  initial
  begin
    op_valid = 1'b0;
    op = sxa_op_none;
    file_addr = '0;
    dest_sel = 1'b0;
    literal = '0;
    load_en = 1'b0;
    load_addr = '0;
    load_data = '0;
  end
  // One-cycle request; operands held until the next request
  task automatic issue(input sxa_op_e o, input int a, input int d, input int k);
    @(posedge clock);
    op_valid <= 1'b1;
    op <= o;
    file_addr <= a[ADDR_W-1:0];
    dest_sel <= d[0];
    literal <= k[DATA_W-1:0];
    @(posedge clock);
    op_valid <= 1'b0;
  endtask
  // Released data shows the inverse of the last value
  task automatic load(input int a, input int v);
    @(posedge clock);
    load_en <= 1'b1;
    load_addr <= a[ADDR_W-1:0];
    load_data <= v[DATA_W-1:0];
    @(posedge clock);
    load_en <= 1'b0;
    load_data <= ~v[DATA_W-1:0];
  endtask
endmodule // sxa_dec_model

/* File: testbench/tb.sv */
// Self-checking bench for the subtract, XOR and swap datapath
`timescale 1ns/1ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("FAIL %0t %s", $time, m); end end
module tb;
  import sxa_pkg::*;
  logic clock;
  logic rstn;
  logic op_valid, dest_sel, load_en, busy, done, file_wr, carry_flag, digit_carry_flag, zero_flag;
  sxa_op_e op;
  logic [ADDR_W-1:0] file_addr, load_addr, file_wr_addr;
  logic [DATA_W-1:0] literal, load_data, result, working, file_wr_data;
  int fail_count, num_checks, w, c, dgc, z;
  int mem [FILE_DEPTH];
  sxa_dec_model dec (.clock(clock), .op_valid(op_valid), .op(op), .file_addr(file_addr),
    .dest_sel(dest_sel), .literal(literal), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data));
  sxa_alu dut (.clock(clock), .rstn(rstn), .op_valid(op_valid), .op(op), .file_addr(file_addr),
    .dest_sel(dest_sel), .literal(literal), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .busy(busy), .done(done), .result(result), .working(working),
    .file_wr(file_wr), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Issue one operation, model it, compare at done
  task automatic run(input sxa_op_e o, input int a, input int d, input int k);
    int f, r, n;
    f = mem[a];
    r = 0;
    n = 0;
    dec.issue(o, a, d, k);
    if (o == sxa_op_xor_literal_op)
      d = 0;
    case (o)
      sxa_op_subtract_from_file_op:
      begin
        r = (f - w) & 255;
        c = (w <= f);
        dgc = ((w & 15) <= (f & 15));
      end
      sxa_op_xor_literal_op: r = w ^ k;
      sxa_op_nibble_swap_op: r = ((f & 15) << 4) | (f >> 4);
      default: r = w ^ f;
    endcase
    if (o != sxa_op_nibble_swap_op)
      z = (r == 0);
    if (d == 0)
      w = r;
    else
      mem[a] = r;
    #1;
    `CHK(busy, 1'b1, "busy in exec")
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (done !== 1'b1 && n < 4);
    `CHK(done, 1'b1, "no done")
    `CHK(n, EXEC_CYCLES - 1, "latency")
    `CHK(result, r[7:0], "result")
    `CHK(working, w[7:0], "working")
    `CHK(file_wr, d[0], "file write strobe")
    if (d == 1)
    begin
      `CHK(file_wr_data, r[7:0], "file data")
      `CHK(file_wr_addr, a[6:0], "file addr")
    end
    `CHK(carry_flag, c[0], "carry")
    `CHK(digit_carry_flag, dgc[0], "digit carry")
    `CHK(zero_flag, z[0], "zero")
  endtask
  initial
  begin
    #(25 * 20000);
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    rstn = 1'b0;
    w = 0;
    c = 0;
    dgc = 0;
    z = 0;
    void'($urandom(54));
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < FILE_DEPTH; i++)
    begin
      mem[i] = $urandom % 256;
      dec.load(i, mem[i]);
    end
    for (int i = 0; i < 400; i++)
      run(sxa_op_e'(1 + $urandom % 4), (i % 8 == 0) ? int'(FILE_ADDR_MAX) * (i % 16 / 8)
        : $urandom % 128,
        $urandom % 2, $urandom % 256);
    $display("test random ops done");
    dec.load(5, w);
    mem[5] = w;
    run(sxa_op_subtract_from_file_op, 5, 0, 0);
    run(sxa_op_xor_literal_op, 0, 1, 8'hff);
    run(sxa_op_subtract_from_file_op, 5, 1, 0);
    $display("test boundary subtract done");
    dec.issue(sxa_op_none, 3, 0, 8'h5a);
    repeat (4)
    begin
      @(posedge clock);
      #1;
      `CHK(done, 1'b0, "none op answered")
    end
    `CHK(working, w[7:0], "none op changed working")
    $display("test refused op done");
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    #1;
    `CHK({busy, done, file_wr, working, result}, 19'h00000, "reset outputs")
    `CHK({carry_flag, digit_carry_flag, zero_flag}, 3'h0, "reset flags")
    @(posedge clock);
    rstn <= 1'b1;
    w = 0;
    c = 0;
    dgc = 0;
    z = 0;
    run(sxa_op_xor_with_file_op, 9, 0, 0);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule // tb
